// [rtl/vsr_consts.svh]
// Timing constants and counter width for the supervisor reset logic.
`ifndef VSR_CONSTS_SVH
`define VSR_CONSTS_SVH
`define VSR_CLK_MHZ 200
`define VSR_TMO_SHORT_MS 15
`define VSR_TMO_LONG_MS 200
`define VSR_TMO_SHORT_CYC (`VSR_TMO_SHORT_MS * 1000 * `VSR_CLK_MHZ)
`define VSR_TMO_LONG_CYC (`VSR_TMO_LONG_MS * 1000 * `VSR_CLK_MHZ)
`define VSR_CNT_W 32
`endif

// [rtl/vsr_pkg.sv]
// Types shared by the supervisor reset logic.
package vsr_pkg;
  typedef enum logic [1:0] {
    VSR_HOLD,
    VSR_TIMING,
    VSR_RELEASED
  } vsr_state_t;
endpackage

// [rtl/vsr_supervisor.sv]
// Digital core of a two-input voltage supervisor with reset timer.
`timescale 1ns/100ps
`include "vsr_consts.svh"
module vsr_supervisor
  import vsr_pkg::*;
#(
  parameter bit HAS_TIMEOUT_SELECT = 1'b1,
  parameter bit SPARE_INVERTING = 1'b0,
  parameter bit ACTIVE_PULLUP = 1'b0,
  parameter int unsigned TMO_SHORT_CYC = `VSR_TMO_SHORT_CYC,
  parameter int unsigned TMO_LONG_CYC = `VSR_TMO_LONG_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic reset_threshold_input_i,
  input wire logic spare_above_thr_i,
  input wire logic spare_above_thr_hys_i,
  input wire logic supply_ok_i,
  input wire logic manual_reset_n_i,
  input wire logic timeout_select_i,
  input wire logic output_logic_supply_i,
  output logic rst_out_n_o,
  output logic rst_out_n_oe_o,
  output logic status_o,
  output logic status_oe_o
);

  // Refuse settings the logic cannot serve. A zero count would wrap the
  // compare and release only once the count reaches all ones. The pull-up variants give the select pin
  // over to the logic supply, so the two options cannot exist together.
  generate
    if (TMO_SHORT_CYC < 1 || TMO_LONG_CYC < 1) begin : g_bad_count
      $error("Timeout counts must be at least one cycle.");
    end
    if (HAS_TIMEOUT_SELECT && ACTIVE_PULLUP) begin : g_bad_variant
      $error("A pull-up variant has no timeout select input.");
    end
  endgenerate

  vsr_state_t state_q, state_d;
  logic [`VSR_CNT_W-1:0] cnt_q, cnt_d;
  logic rst_level_q, stat_q, stat_d;
  wire logic [`VSR_CNT_W-1:0] tmo_cyc;
  wire logic reset_cond;
  wire logic tmo_done;

  // Both pins share one output stage. A low is always driven, and a high
  // only by a powered pull-up stage. Otherwise the pin is let go and the
  // board's resistor lifts it.
  function automatic logic pin_drive_en(input logic lvl, input logic up);
    pin_drive_en = !lvl || up;
  endfunction

  // The input signal is high when the monitored level is above threshold
  // plus hysteresis; the analog comparator supplies that hysteresis.
  assign reset_cond = !supply_ok_i || !reset_threshold_input_i
    || !manual_reset_n_i;
  assign tmo_cyc = (HAS_TIMEOUT_SELECT && !timeout_select_i)
    ? `VSR_CNT_W'(TMO_SHORT_CYC) : `VSR_CNT_W'(TMO_LONG_CYC);
  assign tmo_done = (cnt_q >= tmo_cyc - `VSR_CNT_W'(1));

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      VSR_HOLD: begin
        cnt_d = '0;
        if (!reset_cond) state_d = VSR_TIMING;
      end
      VSR_TIMING: begin
        cnt_d = cnt_q + `VSR_CNT_W'(1);
        if (reset_cond) begin
          state_d = VSR_HOLD;
          cnt_d = '0;
        end else if (tmo_done) begin
          state_d = VSR_RELEASED;
        end
      end
      default: begin
        if (reset_cond) state_d = VSR_HOLD;
      end
    endcase
  end

  // Spare comparator: the two inputs give threshold and threshold with
  // hysteresis, so the output latches until the far edge is crossed.
  always_comb begin
    stat_d = stat_q;
    if (!SPARE_INVERTING) begin
      if (!spare_above_thr_i) stat_d = 1'b0;
      else if (spare_above_thr_hys_i) stat_d = 1'b1;
    end else begin
      if (spare_above_thr_i) stat_d = 1'b0;
      else if (!spare_above_thr_hys_i) stat_d = 1'b1;
    end
    if (!supply_ok_i) stat_d = 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_q <= VSR_HOLD;
      cnt_q <= '0;
      stat_q <= 1'b0;
      rst_level_q <= 1'b0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      stat_q <= stat_d;
      rst_level_q <= (state_d == VSR_RELEASED);
    end
  end

  // Open drain when not a pull-up variant or its logic supply is grounded;
  // a low level is always driven, which keeps outputs low in lockout.
  wire logic drive_high = ACTIVE_PULLUP && output_logic_supply_i;
  wire logic [1:0] pin_lvl;
  wire logic [1:0] pin_oe;
  assign pin_lvl = {stat_q, rst_level_q};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      assign pin_oe[gi] = pin_drive_en(pin_lvl[gi], drive_high);
    end
  endgenerate
  assign rst_out_n_o = pin_lvl[0];
  assign rst_out_n_oe_o = pin_oe[0];
  assign status_o = pin_lvl[1];
  assign status_oe_o = pin_oe[1];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  lockout_low_a: assert property (clk_en_i && !supply_ok_i |=>
    !rst_out_n_o && !status_o && rst_out_n_oe_o && status_oe_o)
    else $error("Outputs not low in lockout.");
  thresh_low_a: assert property (clk_en_i && !reset_threshold_input_i |=>
    !rst_out_n_o) else $error("Reset not asserted below threshold.");
  manual_low_a: assert property (clk_en_i && !manual_reset_n_i |=>
    !rst_out_n_o) else $error("Reset not held by manual input.");
  release_cause_a: assert property ($rose(rst_out_n_o) |->
    $past(state_q) == VSR_TIMING && $past(tmo_done))
    else $error("Reset released without timeout.");
  restart_a: assert property (state_q == VSR_TIMING && clk_en_i
    && reset_cond |=> cnt_q == '0 && state_q == VSR_HOLD)
    else $error("Timeout not restarted.");
  sel_short_a: assert property (HAS_TIMEOUT_SELECT && !timeout_select_i
    |-> tmo_cyc == `VSR_CNT_W'(TMO_SHORT_CYC))
    else $error("Short timeout not selected.");
  sel_long_a: assert property ((!HAS_TIMEOUT_SELECT || timeout_select_i)
    |-> tmo_cyc == `VSR_CNT_W'(TMO_LONG_CYC))
    else $error("Long timeout not selected.");
  spare_low_a: assert property (clk_en_i && supply_ok_i
    && (SPARE_INVERTING ? spare_above_thr_i : !spare_above_thr_i)
    |=> !status_o) else $error("Status not pulled low.");
  drive_high_a: assert property (rst_out_n_o && ACTIVE_PULLUP
    && output_logic_supply_i |-> rst_out_n_oe_o)
    else $error("Pull-up high not driven.");


  // Low levels must reach the pin in every output style, and an
  // open-drain high must be let go so the board pull-up can win.
  drive_low_a: assert property (!rst_out_n_o && !status_o
    |-> rst_out_n_oe_o && status_oe_o)
    else $error("Low level not driven.");
  od_release_a: assert property (status_o && !(ACTIVE_PULLUP
    && output_logic_supply_i) |-> !status_oe_o)
    else $error("Open-drain high not released.");
  oe_status_a: assert property (status_o && ACTIVE_PULLUP
    && output_logic_supply_i |-> status_oe_o)
    else $error("Pull-up status high not driven.");

  // The timer only counts enabled cycles, so a frozen clock enable
  // stretches the timeout rather than shortening it.
  timer_step_a: assert property (state_q == VSR_TIMING && clk_en_i
    && !reset_cond && !tmo_done |=> state_q == VSR_TIMING
    && cnt_q == $past(cnt_q) + `VSR_CNT_W'(1))
    else $error("Timeout did not advance by one.");
  freeze_a: assert property (!clk_en_i |=> $stable(state_q)
    && $stable(cnt_q) && $stable(rst_out_n_o) && $stable(status_o))
    else $error("State moved while clock enable was low.");
  manual_rel_a: assert property ($rose(manual_reset_n_i)
    && $past(clk_en_i) && clk_en_i |=> !rst_out_n_o)
    else $error("Reset freed at once after manual release.");
  release_stand_a: assert property (state_q == VSR_RELEASED
    && clk_en_i && !reset_cond |=> rst_out_n_o)
    else $error("Released reset dropped without a cause.");
  lockout_state_a: assert property (clk_en_i && !supply_ok_i
    |=> state_q == VSR_HOLD)
    else $error("Timer not held in lockout.");

  // Inside the hysteresis band the status output keeps its level unless the supply fails; past the band it is released.
  spare_hold_a: assert property (clk_en_i && !status_o
    && (SPARE_INVERTING ? !spare_above_thr_i && spare_above_thr_hys_i
      : spare_above_thr_i && !spare_above_thr_hys_i)
    |=> !status_o) else $error("Status released inside hysteresis.");
  spare_release_a: assert property (clk_en_i && supply_ok_i
    && (SPARE_INVERTING ? !spare_above_thr_i && !spare_above_thr_hys_i
      : spare_above_thr_i && spare_above_thr_hys_i)
    |=> status_o) else $error("Status not released past hysteresis.");

  release_c: cover property ($rose(rst_out_n_o));
  restart_c: cover property (state_q == VSR_TIMING ##1 state_q == VSR_HOLD);
  status_c: cover property ($rose(status_o));
  freeze_c: cover property (!clk_en_i && state_q == VSR_TIMING);
  lockout_c: cover property (!supply_ok_i && state_q == VSR_RELEASED);
endmodule

// [tb/vsr_cpu_model.sv]
// Processor side model: reset and interrupt inputs on pulled-up lines.
`timescale 1ns/100ps
module vsr_cpu_model (
  input wire logic rst_lvl_i,
  input wire logic rst_oe_i,
  input wire logic sts_lvl_i,
  input wire logic sts_oe_i,
  output logic cpu_rst_n_o,
  output logic cpu_nmi_n_o
);
  // A released open-drain line rises through its pull-up resistor.
  assign cpu_rst_n_o = rst_oe_i ? rst_lvl_i : 1'b1;
  assign cpu_nmi_n_o = sts_oe_i ? sts_lvl_i : 1'b1;
endmodule

// [tb/test_vsr_supervisor.sv]
// Self-checking bench for the supervisor reset logic.
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %b got %b", n, e, s); end end
module test_vsr_supervisor;
  logic clk = 0, rst_b = 0, thr = 1, sa = 1, sh = 1, sup = 1, mr = 1, ts = 0;
  logic en = 1, dls = 0;
  wire logic ro, roe, so, soe, wr, wn;
  wire logic ro2, roe2, so2, soe2;
  int fails = 0, n_compared = 0;
  // Short counts keep the run brief; expectations use the same values.
  vsr_supervisor #(.TMO_SHORT_CYC(5), .TMO_LONG_CYC(20)) dut (
    .sys_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(en),
    .reset_threshold_input_i(thr), .spare_above_thr_i(sa),
    .spare_above_thr_hys_i(sh), .supply_ok_i(sup),
    .manual_reset_n_i(mr), .timeout_select_i(ts),
    .output_logic_supply_i(1'b0), .rst_out_n_o(ro),
    .rst_out_n_oe_o(roe), .status_o(so), .status_oe_o(soe));
  // Fixed-timeout, inverting, pull-up variant on the same inputs, except its logic supply comes from dls.
  vsr_supervisor #(.HAS_TIMEOUT_SELECT(1'b0), .SPARE_INVERTING(1'b1),
    .ACTIVE_PULLUP(1'b1), .TMO_SHORT_CYC(5), .TMO_LONG_CYC(20)) dut_inv (
    .sys_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(en),
    .reset_threshold_input_i(thr), .spare_above_thr_i(sa),
    .spare_above_thr_hys_i(sh), .supply_ok_i(sup),
    .manual_reset_n_i(mr), .timeout_select_i(ts),
    .output_logic_supply_i(dls), .rst_out_n_o(ro2),
    .rst_out_n_oe_o(roe2), .status_o(so2), .status_oe_o(soe2));
  vsr_cpu_model cpu (.rst_lvl_i(ro), .rst_oe_i(roe), .sts_lvl_i(so),
    .sts_oe_i(soe), .cpu_rst_n_o(wr), .cpu_nmi_n_o(wn));
  initial forever #2.5 clk = ~clk;
  task cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task rel(int n);
    cyc(n);
    `CHK("rst held", 1'b0, wr)
    cyc(1);
    `CHK("rst freed", 1'b1, wr)
  endtask
  task t_manual;
    mr = 0;
    cyc(4);
    `CHK("mr low", 1'b0, wr)
    mr = 1;
    ts = 1;
    rel(20);
  endtask
  task t_restart;
    ts = 0;
    thr = 0;
    cyc(1);
    `CHK("thr low", 1'b0, wr)
    thr = 1;
    cyc(3);
    thr = 0;
    cyc(1);
    thr = 1;
    en = 0;
    cyc(4);
    en = 1;
    rel(5);
  endtask
  task t_spare;
    sa = 0;
    sh = 0;
    cyc(1);
    `CHK("sts low", 1'b0, wn)
    sa = 1;
    cyc(2);
    `CHK("sts hys", 1'b0, wn)
    sh = 1;
    cyc(1);
    `CHK("sts up", 1'b1, wn)
  endtask
  task t_uvlo;
    sup = 0;
    cyc(3);
    `CHK("uv rst", 1'b0, wr)
    `CHK("uv sts", 1'b0, wn)
    sup = 1;
    rel(5);
    rst_b = 0;
    cyc(2);
    `CHK("rst in reset", 1'b0, wr)
    `CHK("sts in reset", 1'b0, wn)
    rst_b = 1;
    rel(5);
  endtask
  task t_variant;
    dls = 1;
    thr = 0;
    cyc(1);
    `CHK("fix low", 1'b0, ro2)
    thr = 1;
    cyc(20);
    `CHK("fix held", 1'b0, ro2)
    cyc(1);
    `CHK("fix freed", 1'b1, ro2)
    `CHK("pu drive", 1'b1, roe2)
    dls = 0;
    sa = 0;
    cyc(1);
    `CHK("pu od", 1'b0, roe2)
    `CHK("inv hys", 1'b0, so2)
    sh = 0;
    cyc(1);
    `CHK("inv up", 1'b1, so2)
    `CHK("inv od", 1'b0, soe2)
    sa = 1;
    sh = 1;
    cyc(1);
    `CHK("inv low", 1'b0, so2)
  endtask
  task wrap_up;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    cyc(16);
    rst_b = 1;
    rel(5);
    t_manual;
    t_restart;
    t_spare;
    t_uvlo;
    t_variant;
    wrap_up;
  end
  initial begin
    #2000;
    fails++;
    wrap_up;
  end
endmodule
